// file: src/twmc_decoder.sv
// Purpose: three-wire motor command decoder
// Assumes: command pins are asynchronous and pass a two-flop synchroniser
// Notes:   one ref_clk cycle is one control cycle
//
// Overview of operation
// (RULE1) selection 3: enable, cw start, ccw start; selection resets to 0
// (RULE2) selection 4: inputs are enable, start, reverse
// (RULE3) enable/start/reverse: motor never starts while enable is low
// (RULE4) enable/start/reverse: start switches motor on while enable high
// (RULE5) enable/start/reverse: reverse high inverts rotation direction
// (RULE6) dropping enable issues a ramp-down stop
// (RULE7) enable low keeps motor stopped whatever start and reverse do
// (RULE8) enable 1, reverse 0, start rising: run clockwise
// (RULE9) enable 1, reverse 1, start rising: run counter-clockwise
// (RULE10) control word bit 0 is run, bit 1 is setpoint inversion
// (RULE11) negative-direction inhibit resets to 1 and blocks reversed rotation
// (RULE12) outside party drives enable, start, reverse on inputs one to three
// (RULE13) cw/ccw: start edge picks direction; both high or enable low stops
// (RULE14) edges found against previous sample, acted on only while enabled
`timescale 1ns/100ps
module twmc_decoder (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// command pins
	input  wire twmc_pkg::twmc_cmd_t cmd_pins,
	// configuration
	input  wire logic [2:0]         wire_control_selection,
	input  wire logic               negative_direction_inhibit,
	// drive side
	output twmc_pkg::twmc_word_t    decoded_control_word,
	output logic                    ramp_stop_command
);

	// ----------------------------------------------------------------
	// synchronise pins
	// ----------------------------------------------------------------
	twmc_pkg::twmc_cmd_t cmd_sync;
	twmc_pkg::twmc_cmd_t cmd_prev_reg;

	twmc_sync #(.WIDTH(3)) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in (cmd_pins),
		.sync_out (cmd_sync)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire enable_in = cmd_sync.first_digital_input;   // RULE12
	wire two_in    = cmd_sync.second_digital_input;
	wire three_in  = cmd_sync.third_digital_input;
	wire mode_cw   = wire_control_selection ==
		twmc_pkg::SEL_ENABLE_CW_CCW;                 // RULE1
	wire mode_rev  = wire_control_selection ==
		twmc_pkg::SEL_ENABLE_ON_REV;                 // RULE2
	wire active    = mode_cw | mode_rev;
	wire rise_two  = two_in & ~cmd_prev_reg.second_digital_input;   // RULE14
	wire rise_thr  = three_in & ~cmd_prev_reg.third_digital_input;  // RULE14

	// cw/ccw scheme
	wire cw_start  = rise_two & ~three_in;           // RULE13
	wire ccw_start = rise_thr & ~two_in;             // RULE13
	wire cw_both   = two_in & three_in;              // RULE13

	// enable/start/reverse scheme
	wire on_start  = rise_two;                       // RULE4
	wire on_rev    = three_in;                       // RULE5

	wire start_cw  = mode_cw ? cw_start : (on_start & ~on_rev);  // RULE8
	wire start_ccw = mode_cw ? ccw_start : (on_start & on_rev);  // RULE9
	wire ccw_ok    = start_ccw & ~negative_direction_inhibit;    // RULE11

	logic run_reg;
	logic inv_reg;
	logic run_next;
	logic inv_next;

	always_comb begin
		run_next = run_reg;
		inv_next = inv_reg;
		if (!active || !enable_in) begin
			run_next = 1'h0;                         // RULE3 RULE6 RULE7
			inv_next = 1'h0;
		end else if (mode_cw && cw_both) begin
			run_next = 1'h0;                         // RULE13
			inv_next = 1'h0;
		end else if (start_cw) begin
			run_next = 1'h1;                         // RULE8
			inv_next = 1'h0;
		end else if (ccw_ok) begin
			run_next = 1'h1;                         // RULE9
			inv_next = 1'h1;
		end else if (mode_rev && run_reg) begin
			inv_next = on_rev & ~negative_direction_inhibit;  // RULE5 RULE11
		end
		// inhibit raised while running reversed drops back to clockwise
		if (negative_direction_inhibit) begin
			inv_next = 1'h0;                         // RULE11
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmd_prev_reg <= '0;
			run_reg      <= 1'h0;
			inv_reg      <= 1'h0;
		end else begin
			cmd_prev_reg <= cmd_sync;
			run_reg      <= run_next;
			inv_reg      <= inv_next;
		end
	end

	// RULE10
	assign decoded_control_word = '{
		setpoint_inversion_source: inv_reg,
		run_or_ramp_stop:          run_reg
	};
	assign ramp_stop_command = ~run_reg;             // RULE6

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	// enable drop, start conditions of both schemes and the registered answers
	sequence enable_drop_s;
		$fell(enable_in);
	endsequence

	sequence rev_cw_pick_s;
		mode_rev && enable_in && rise_two && !three_in;
	endsequence

	sequence rev_ccw_pick_s;
		mode_rev && enable_in && rise_two && three_in &&
			!negative_direction_inhibit;
	endsequence

	sequence cw_pick_s;
		mode_cw && enable_in && rise_two && !three_in;
	endsequence

	sequence ccw_pick_s;
		mode_cw && enable_in && rise_thr && !two_in &&
			!negative_direction_inhibit;
	endsequence

	sequence run_cw_s;
		run_reg && !inv_reg;
	endsequence

	sequence run_ccw_s;
		run_reg && inv_reg;
	endsequence

	stop_on_disable_a: assert property ( // RULE6
		@(posedge ref_clk) disable iff (rst)
		enable_drop_s |=> !run_reg)
		else $error("run stays after enable drop");

	hold_stopped_a: assert property ( // RULE7
		@(posedge ref_clk) disable iff (rst)
		!enable_in |=> !run_reg && !inv_reg)
		else $error("motor runs with enable low");

	no_start_a: assert property ( // RULE3
		@(posedge ref_clk) disable iff (rst)
		(mode_rev && !enable_in) |=> !run_reg)
		else $error("started without enable");

	cw_start_a: assert property ( // RULE8
		@(posedge ref_clk) disable iff (rst)
		rev_cw_pick_s |=> run_cw_s)
		else $error("clockwise start missed");

	ccw_start_a: assert property ( // RULE9
		@(posedge ref_clk) disable iff (rst)
		rev_ccw_pick_s |=> run_ccw_s)
		else $error("counter-clockwise start missed");

	inhibit_block_a: assert property ( // RULE11
		@(posedge ref_clk) disable iff (rst)
		negative_direction_inhibit |=> !inv_reg)
		else $error("reverse despite inhibit");

	both_stop_a: assert property ( // RULE13
		@(posedge ref_clk) disable iff (rst)
		(mode_cw && two_in && three_in) |=> !run_reg)
		else $error("both starts high did not stop");

	pick_cw_a: assert property ( // RULE13
		@(posedge ref_clk) disable iff (rst)
		cw_pick_s |=> run_cw_s)
		else $error("clockwise pick missed");

	pick_ccw_a: assert property ( // RULE13
		@(posedge ref_clk) disable iff (rst)
		ccw_pick_s |=> run_ccw_s)
		else $error("counter-clockwise pick missed");

	reverse_flip_a: assert property ( // RULE5
		@(posedge ref_clk) disable iff (rst)
		(mode_rev && enable_in && run_reg && three_in &&
			!negative_direction_inhibit && !rise_two) |=> inv_reg)
		else $error("reverse not applied");

	inactive_mode_a: assert property ( // RULE1
		@(posedge ref_clk) disable iff (rst)
		!active |=> !run_reg)
		else $error("runs in unsupported selection");

	word_map_a: assert property ( // RULE10
		@(posedge ref_clk) disable iff (rst)
		ramp_stop_command ==
			!decoded_control_word[twmc_pkg::CW_RUN_BIT])
		else $error("control word mismatch");

	inv_needs_run_a: assert property ( // RULE10
		@(posedge ref_clk) disable iff (rst)
		decoded_control_word[twmc_pkg::CW_INVERT_BIT] |->
			decoded_control_word[twmc_pkg::CW_RUN_BIT])
		else $error("inversion while stopped");

endmodule : twmc_decoder

// file: src/twmc_pkg.sv
// Purpose: shared constants and types of the three-wire motor command decoder
// Assumes: one control cycle per rising ref_clk edge
// Notes:   selection codes and reset values live here only
package twmc_pkg;

	// ----------------------------------------------------------------
	// wire-control selection codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SEL_WIDTH_DUMMY      = 3'h0;
	localparam logic [2:0] SEL_RESET            = 3'h0;
	localparam logic [2:0] SEL_ENABLE_CW_CCW    = 3'h3;
	localparam logic [2:0] SEL_ENABLE_ON_REV    = 3'h4;
	localparam logic       NEG_INHIBIT_RESET    = 1'h1;

	// ----------------------------------------------------------------
	// control word field positions
	// ----------------------------------------------------------------
	localparam int         CW_RUN_BIT           = 0;
	localparam int         CW_INVERT_BIT        = 1;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic third_digital_input;
		logic second_digital_input;
		logic first_digital_input;
	} twmc_cmd_t;

	typedef struct packed {
		logic setpoint_inversion_source;
		logic run_or_ramp_stop;
	} twmc_word_t;

endpackage : twmc_pkg

// file: src/twmc_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are asynchronous to ref_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module twmc_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : twmc_sync

// file: verification/tb.sv
// Purpose: self-checking bench of the motor command decoder
// Assumes: pins are {reverse, start, enable}, word is {inv, run}
// Notes:   each step waits past the three-edge answer delay
`timescale 1ns/100ps
module tb;
	logic                 ref_clk = 1'h0;
	logic                 rst     = 1'h1;
	logic [2:0]           sel     = 3'h0;
	logic                 inh     = 1'h1;
	logic [2:0]           rs;
	logic [31:0]          r;
	twmc_pkg::twmc_cmd_t  want    = '0;
	twmc_pkg::twmc_cmd_t  cmd_pins;
	twmc_pkg::twmc_word_t decoded_control_word;
	logic                 ramp_stop_command;
	twmc_pkg::twmc_word_t exp_q[$];
	twmc_pkg::twmc_word_t e;
	int                   fail_count = 0;
	int                   n_checks   = 0;
	int                   n_steps    = 0;
	int                   seed       = 32'hc407;

	always #20 ref_clk = ~ref_clk;

	twmc_switches u_twmc_switches (.ref_clk(ref_clk), .want(want),
		.cmd_pins(cmd_pins));
	twmc_decoder u_twmc_decoder (.ref_clk(ref_clk), .rst(rst),
		.cmd_pins(cmd_pins), .wire_control_selection(sel),
		.negative_direction_inhibit(inh),
		.decoded_control_word(decoded_control_word),
		.ramp_stop_command(ramp_stop_command));

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	task automatic step(input logic [2:0] s, input logic i,
		input logic [2:0] p, input logic [1:0] x);
		@(negedge ref_clk);
		sel = s;
		inh = i;
		want <= p;
		repeat (5) @(negedge ref_clk);
		@(posedge ref_clk);
		exp_q.push_back(x);
		n_steps++;
		$display("step %0d done", n_steps);
	endtask : step

	// ----------------------------------------------------------------
	// monitor: compares outputs with the oldest note
	// ----------------------------------------------------------------
	always @(negedge ref_clk) begin
		if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			n_checks++;
			if (decoded_control_word !== e ||
				ramp_stop_command !== !e.run_or_ramp_stop) begin
				fail_count++;
				$display("CHECK FAILED %0t word %b", $time,
					decoded_control_word);
			end
		end
	end

	initial begin
		#40000;
		fail_count++;
		final_report();
	end

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(negedge ref_clk);
		rst = 1'h0;
		step(3'h0, 1'h1, 3'h0, 2'h0);
		step(3'h4, 1'h0, 3'h2, 2'h0);
		step(3'h4, 1'h0, 3'h3, 2'h0);
		step(3'h4, 1'h0, 3'h1, 2'h0);
		step(3'h4, 1'h0, 3'h3, 2'h1);
		step(3'h4, 1'h0, 3'h7, 2'h3);
		step(3'h4, 1'h0, 3'h6, 2'h0);
		step(3'h4, 1'h0, 3'h5, 2'h0);
		step(3'h4, 1'h0, 3'h7, 2'h3);
		step(3'h4, 1'h1, 3'h4, 2'h0);
		step(3'h4, 1'h1, 3'h5, 2'h0);
		step(3'h4, 1'h1, 3'h7, 2'h0);
		step(3'h3, 1'h0, 3'h1, 2'h0);
		step(3'h3, 1'h0, 3'h3, 2'h1);
		step(3'h3, 1'h0, 3'h7, 2'h0);
		step(3'h3, 1'h0, 3'h5, 2'h0);
		step(3'h3, 1'h0, 3'h1, 2'h0);
		step(3'h3, 1'h0, 3'h5, 2'h3);
		step(3'h3, 1'h0, 3'h4, 2'h0);
		step(3'h3, 1'h0, 3'h1, 2'h0);
		step(3'h3, 1'h0, 3'h3, 2'h1);
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			rs = r[2:0];
			if (rs == 3'h3 || rs == 3'h4) begin
				rs = 3'h7;
			end
			step(rs, r[6], r[5:3], 2'h0);
		end
		repeat (2) @(negedge ref_clk);
		final_report();
	end
endmodule : tb

// file: verification/twmc_switches.sv
// Purpose: model of the switches that drive the command pins
// Assumes: the bench sets the wanted levels at the falling edge
// Notes:   levels reach the pins one falling edge later
`timescale 1ns/100ps
module twmc_switches (
	// clock
	input  wire logic                ref_clk,
	// wanted and driven levels
	input  wire twmc_pkg::twmc_cmd_t want,
	output twmc_pkg::twmc_cmd_t      cmd_pins
);
	initial cmd_pins = '0;
	always @(negedge ref_clk) begin
		cmd_pins <= want;
	end
endmodule : twmc_switches
